// ===== hw/mpi_pkg.sv
// Notes on behaviour
// - Erase-all clears flash, EEPROM, locks; fuses kept.
// - Locks stay programmed until both arrays erased.
// - Flash write cannot raise bits; erase first.
// - Erased cells read all ones; EEPROM self-erases.
// - Fuse readback bit order fixed, bits five-zero.
// - Byte select high shows lock bits two, one.
// - Signature read: command, address, output enable low.
// - Flash and EEPROM have separate zero-based spaces.
// - Serial clock phases exceed two oscillator cycles.
// - Data sampled on rising, shifted out falling.
// - Power-up keeps reset and serial clock low.
// - Wait twenty milliseconds before programming enable.
// - Second byte echoed during third; four bytes always.
// - Missing echo: one clock pulse, retry enable.
// - After erase-all wait, pulse reset, re-enable.
// - One byte per write instruction, address included.
// - Wait write delay before next instruction.
// - Read instruction returns addressed byte serially.
// - Reset released high ends programming mode.
// - Programmer may skip all-ones bytes when writing.
// - Byte select low picks low, high picks high.
// - Ready-busy low while programming, high when ready.
package mpi_pkg;
  localparam int CLK_MHZ        = 200;
  localparam int PWRUP_WAIT_MS  = 20;
  localparam int ERASE_WAIT_MS  = 18;
  localparam int WRITE_WAIT_MS  = 9;
  localparam int ERASE_SELF_MS  = 8;
  localparam int WRITE_SELF_MS  = 4;
  localparam int PWRUP_WAIT_CYC = PWRUP_WAIT_MS * 1000 * CLK_MHZ;
  localparam int ERASE_WAIT_CYC = ERASE_WAIT_MS * 1000 * CLK_MHZ;
  localparam int WRITE_WAIT_CYC = WRITE_WAIT_MS * 1000 * CLK_MHZ;
  localparam int ERASE_SELF_CYC = ERASE_SELF_MS * 1000 * CLK_MHZ;
  localparam int WRITE_SELF_CYC = WRITE_SELF_MS * 1000 * CLK_MHZ;
  localparam int SCK_MIN_PHASE  = 2;
  localparam int SCK_HALF_DEF   = 4 * SCK_MIN_PHASE;
  localparam int FLASH_AW       = 11;
  localparam int EE_AW          = 7;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] OP_PREFIX   = 8'hac;
  localparam logic [7:0] SUB_PROG_EN = 8'h53;
  localparam logic [7:0] SUB_ERASE   = 8'h80;
  localparam logic [7:0] SUB_LOCK    = 8'he0;
  localparam logic [7:0] OP_RD_FLASH = 8'h20;
  localparam logic [7:0] OP_WR_FLASH = 8'h40;
  localparam logic [7:0] OP_HI_MASK  = 8'h08;
  localparam logic [7:0] OP_RD_EE    = 8'ha0;
  localparam logic [7:0] OP_WR_EE    = 8'hc0;
  localparam logic [7:0] OP_RD_SIG   = 8'h30;
  localparam logic [7:0] OP_RD_FUSE  = 8'h50;
  localparam logic [7:0] OP_RD_LOCK  = 8'h58;
  localparam logic [7:0] PCMD_ERASE  = 8'h80;
  localparam logic [7:0] PCMD_RD_SIG = 8'h08;
  localparam logic [7:0] PCMD_RD_FL  = 8'h04;
  localparam logic [1:0] CA_LOAD_ADDR = 2'b00;
  localparam logic [1:0] CA_LOAD_CMD  = 2'b10;
  localparam logic [5:0] FUSE_RESET   = 6'h1a;
  localparam logic [1:0] LOCK_RESET   = 2'b11;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_TX   = 12'h004;
  localparam logic [11:0] REG_RX   = 12'h008;
  localparam logic [11:0] REG_STAT = 12'h00c;
  localparam logic [11:0] REG_PAR  = 12'h010;
  localparam int CTRL_HOLD  = 0;
  localparam int CTRL_GO    = 1;
  localparam int CTRL_PULSE = 2;
  localparam int CTRL_SKIP  = 3;
  localparam int PAR_CA_LO  = 8;
  localparam int PAR_BSEL   = 10;
  localparam int PAR_OE_N   = 11;
  localparam int PAR_LOAD   = 12;
endpackage

// ===== hw/mpi_if.sv
`timescale 1ns/10ps
interface mpi_if;
  logic       prog_reset_n;
  logic       sck;
  logic       mosi;
  logic       miso;
  logic       clock_action_bit1;
  logic       clock_action_bit0;
  logic       par_load;
  logic       byte_select;
  logic       oe_n;
  logic [7:0] par_wdata;
  logic [7:0] par_rdata;
  logic       par_rdata_oe;
  logic       ready_busy_out;
  modport dev (input prog_reset_n, sck, mosi, clock_action_bit1, clock_action_bit0,
               par_load, byte_select, oe_n, par_wdata,
               output miso, par_rdata, par_rdata_oe, ready_busy_out);
  modport prog (output prog_reset_n, sck, mosi, clock_action_bit1, clock_action_bit0,
                par_load, byte_select, oe_n, par_wdata,
                input miso, par_rdata, par_rdata_oe, ready_busy_out);
endinterface

// ===== hw/mpi_dev.sv
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
module mpi_dev #(
  parameter int         ERASE_SELF_CYC = mpi_pkg::ERASE_SELF_CYC,
  parameter int         WRITE_SELF_CYC = mpi_pkg::WRITE_SELF_CYC,
  parameter int         FLASH_AW       = mpi_pkg::FLASH_AW,
  parameter int         EE_AW          = mpi_pkg::EE_AW,
  parameter logic [5:0] FUSE_INIT      = mpi_pkg::FUSE_RESET,
  parameter logic [7:0] SIG0           = 8'h1e, // Arbitrary value.
  parameter logic [7:0] SIG1           = 8'h42, // Arbitrary value.
  parameter logic [7:0] SIG2           = 8'h07  // Arbitrary value.
) (
  input  wire logic pclk,
  input  wire logic presetn,
  mpi_if.dev        link,
  output logic      prog_mode,
  output logic      busy
);
  import mpi_pkg::*;
  localparam int BW = $clog2(ERASE_SELF_CYC + WRITE_SELF_CYC + 1);
  localparam logic [FLASH_AW-1:0] SWEEP_LAST = '1;

  logic [15:0] sync1_ff, sync2_ff;
  logic        sck_d_ff, load_d_ff;
  logic        rst_s, sck_s, mosi_s, load_s, bsel_s, oe_n_s;
  logic [1:0]  ca_s;
  logic [7:0]  pdata_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle pin levels, so that no false sck or load edge follows reset.
      sync1_ff  <= 16'h8100;
      sync2_ff  <= 16'h8100;
      sck_d_ff  <= 1'b0;
      load_d_ff <= 1'b0;
    end else begin
      sync1_ff  <= {link.prog_reset_n, link.sck, link.mosi, link.clock_action_bit1,
                    link.clock_action_bit0, link.par_load, link.byte_select, link.oe_n,
                    link.par_wdata};
      sync2_ff  <= sync1_ff;
      sck_d_ff  <= sck_s;
      load_d_ff <= load_s;
    end
  end
  assign {rst_s, sck_s, mosi_s, ca_s, load_s, bsel_s, oe_n_s, pdata_s} = sync2_ff;

  logic in_prog, sck_rise, sck_fall, load_edge;
  assign in_prog   = ~rst_s;
  assign sck_rise  = in_prog & sck_s & ~sck_d_ff;
  assign sck_fall  = in_prog & ~sck_s & sck_d_ff;
  assign load_edge = in_prog & load_s & ~load_d_ff;

  logic [2:0]  bit_cnt_ff;
  logic [1:0]  byte_cnt_ff;
  logic [7:0]  shift_ff, tx_ff, load_ff, nxt_load;
  logic [15:0] instr_ff;
  logic [7:0]  op_ff;
  logic        enabled_ff;
  logic [7:0]  rx_byte;
  logic        byte_done, exec;
  assign rx_byte   = {shift_ff[6:0], mosi_s};
  assign byte_done = sck_rise & (bit_cnt_ff == 3'd7);
  assign exec      = byte_done & (byte_cnt_ff == 2'd3);

  logic [FLASH_AW-1:0] faddr;
  logic [EE_AW-1:0]    eaddr;
  logic [15:0]         waddr;
  logic [7:0]          flash_mem [0:(1<<FLASH_AW)-1];
  logic [7:0]          ee_mem [0:(1<<EE_AW)-1];
  logic [5:0]          fuse_ff;
  logic [1:0]          lock_ff;
  logic [7:0]          rd_data, sig_byte;
  // Byte address: word address from bytes 1 and 2, half select from the opcode.
  assign waddr = (byte_cnt_ff == 2'd2) ? {instr_ff[15:8], rx_byte} : instr_ff;
  assign faddr = {waddr[FLASH_AW-2:0], (op_ff & OP_HI_MASK) != 8'h00};
  assign eaddr = waddr[EE_AW-1:0];

  always_comb begin
    unique case (waddr[1:0])
      2'd0:    sig_byte = SIG0;
      2'd1:    sig_byte = SIG1;
      2'd2:    sig_byte = SIG2;
      default: sig_byte = ERASED_BYTE;
    endcase
  end

  // A serial read during a self-timed cycle returns all ones rather than stale data.
  always_comb begin
    rd_data = ERASED_BYTE;
    if (enabled_ff && !busy) begin
      if ((op_ff & ~OP_HI_MASK) == OP_RD_FLASH) rd_data = flash_mem[faddr];
      else if (op_ff == OP_RD_EE) rd_data = ee_mem[eaddr];
      else if (op_ff == OP_RD_SIG) rd_data = sig_byte;
      else if (op_ff == OP_RD_FUSE) rd_data = {2'b00, fuse_ff};
      else if (op_ff == OP_RD_LOCK) rd_data = {5'b00000, lock_ff, 1'b0};
    end
  end

  always_comb begin
    nxt_load = 8'h00;
    if (byte_cnt_ff == 2'd1) nxt_load = rx_byte;
    else if (byte_cnt_ff == 2'd2) nxt_load = rd_data;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_ff  <= 3'd0;
      byte_cnt_ff <= 2'd0;
      shift_ff    <= 8'h00;
      instr_ff    <= 16'h0000;
      op_ff       <= 8'h00;
      load_ff     <= 8'h00;
    end else if (!in_prog) begin
      bit_cnt_ff  <= 3'd0;
      byte_cnt_ff <= 2'd0;
    end else if (sck_rise) begin
      shift_ff   <= rx_byte;
      bit_cnt_ff <= bit_cnt_ff + 3'd1;
      if (byte_done) begin
        byte_cnt_ff <= byte_cnt_ff + 2'd1;
        load_ff     <= nxt_load;
        if (byte_cnt_ff == 2'd0) op_ff <= rx_byte;
        if (byte_cnt_ff == 2'd1) instr_ff[15:8] <= rx_byte;
        if (byte_cnt_ff == 2'd2) instr_ff[7:0] <= rx_byte;
      end
    end
  end

  // The first falling edge of a byte loads it, so bit 7 is out before its rising edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_ff <= 8'h00;
    else if (!in_prog) tx_ff <= 8'h00;
    else if (sck_fall) begin
      if (bit_cnt_ff == 3'd0) tx_ff <= load_ff;
      else tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end
  assign link.miso = tx_ff[7];

  logic ser_prefix, ser_erase, ser_lock, ser_wr_flash, ser_wr_ee;
  logic par_erase, erase_start, write_start;
  assign ser_prefix   = exec & (op_ff == OP_PREFIX);
  assign ser_erase    = ser_prefix & enabled_ff & (instr_ff[15:8] == SUB_ERASE) & ~busy;
  assign ser_lock     = ser_prefix & enabled_ff & (instr_ff[15:8] == SUB_LOCK) & ~busy;
  assign ser_wr_flash = exec & enabled_ff & ~busy & ((op_ff & ~OP_HI_MASK) == OP_WR_FLASH);
  assign ser_wr_ee    = exec & enabled_ff & ~busy & (op_ff == OP_WR_EE);
  assign par_erase    = load_edge & (ca_s == CA_LOAD_CMD) & (pdata_s == PCMD_ERASE) & ~busy;
  assign erase_start  = ser_erase | par_erase;
  assign write_start  = ser_wr_flash | ser_wr_ee;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) enabled_ff <= 1'b0;
    else if (!in_prog) enabled_ff <= 1'b0;
    else if (ser_prefix && instr_ff[15:8] == SUB_PROG_EN) enabled_ff <= 1'b1;
  end

  logic                erase_ff;
  logic [FLASH_AW-1:0] sweep_ff;
  logic [BW-1:0]       busy_cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_ff    <= 1'b0;
      sweep_ff    <= '0;
      busy_cnt_ff <= '0;
    end else begin
      if (erase_start) begin
        erase_ff    <= 1'b1;
        sweep_ff    <= '0;
        busy_cnt_ff <= BW'(ERASE_SELF_CYC);
      end else begin
        if (write_start) busy_cnt_ff <= BW'(WRITE_SELF_CYC);
        else if (busy_cnt_ff != '0) busy_cnt_ff <= busy_cnt_ff - BW'(1);
        if (erase_ff) begin
          sweep_ff <= sweep_ff + FLASH_AW'(1);
          if (sweep_ff == SWEEP_LAST) erase_ff <= 1'b0;
        end
      end
    end
  end
  assign busy = erase_ff | (busy_cnt_ff != '0);

  // Flash writes can only clear bits, so an unerased cell keeps its old zeros at zero.
  always_ff @(posedge pclk) begin
    if (erase_ff) begin
      flash_mem[sweep_ff] <= ERASED_BYTE;
      if (sweep_ff < FLASH_AW'(1 << EE_AW)) ee_mem[sweep_ff[EE_AW-1:0]] <= ERASED_BYTE;
    end else if (ser_wr_flash) begin
      flash_mem[faddr] <= flash_mem[faddr] & rx_byte;
    end else if (ser_wr_ee) begin
      ee_mem[eaddr] <= rx_byte;
    end
  end

  // Fuses are never touched by erase; locks clear only after the last cell.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_ff <= 6'h00;
      lock_ff <= LOCK_RESET;
    end else begin
      if (!in_prog && !prog_mode) fuse_ff <= FUSE_INIT;
      if (erase_ff && sweep_ff == SWEEP_LAST) lock_ff <= LOCK_RESET;
      else if (ser_lock) lock_ff <= lock_ff & rx_byte[2:1];
    end
  end

  logic [7:0] pcmd_ff, paddr_ff, prd_ff;
  logic       poe_ff, rb_ff, pm_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcmd_ff  <= 8'h00;
      paddr_ff <= 8'h00;
    end else if (load_edge) begin
      if (ca_s == CA_LOAD_CMD) pcmd_ff <= pdata_s;
      else if (ca_s == CA_LOAD_ADDR) paddr_ff <= pdata_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prd_ff <= 8'h00;
      poe_ff <= 1'b0;
      rb_ff  <= 1'b0;
      pm_ff  <= 1'b0;
    end else begin
      poe_ff <= in_prog & ~oe_n_s;
      rb_ff  <= ~busy;
      pm_ff  <= in_prog;
      prd_ff <= ERASED_BYTE;
      if (pcmd_ff == PCMD_RD_SIG && !bsel_s) begin
        unique case (paddr_ff[1:0])
          2'd0:    prd_ff <= SIG0;
          2'd1:    prd_ff <= SIG1;
          2'd2:    prd_ff <= SIG2;
          default: prd_ff <= ERASED_BYTE;
        endcase
      end else if (pcmd_ff == PCMD_RD_FL) begin
        if (bsel_s) prd_ff <= {5'b00000, lock_ff, 1'b0};
        else prd_ff <= {2'b00, fuse_ff};
      end
    end
  end
  assign link.par_rdata      = prd_ff;
  assign link.par_rdata_oe   = poe_ff;
  assign link.ready_busy_out = rb_ff;
  assign prog_mode           = pm_ff;
endmodule

// ===== hw/mpi_prog.sv
`timescale 1ns/10ps
module mpi_prog #(
  parameter int PWRUP_WAIT_CYC = mpi_pkg::PWRUP_WAIT_CYC,
  parameter int ERASE_WAIT_CYC = mpi_pkg::ERASE_WAIT_CYC,
  parameter int WRITE_WAIT_CYC = mpi_pkg::WRITE_WAIT_CYC,
  parameter int SCK_HALF_CYC   = mpi_pkg::SCK_HALF_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  mpi_if.prog              link
);
  import mpi_pkg::*;
  localparam int WW = $clog2(PWRUP_WAIT_CYC + ERASE_WAIT_CYC + 1);
  localparam int DW = $clog2(SCK_HALF_CYC + 1);

  logic [9:0]  sync1_ff, sync2_ff;
  logic        miso_s, rb_s;
  logic [7:0]  prd_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 10'h000;
      sync2_ff <= 10'h000;
    end else begin
      sync1_ff <= {link.miso, link.ready_busy_out, link.par_rdata};
      sync2_ff <= sync1_ff;
    end
  end
  assign {miso_s, rb_s, prd_s} = sync2_ff;

  logic wr_en, rd_setup, mapped;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped   = (paddr == REG_CTRL) | (paddr == REG_TX) | (paddr == REG_RX) |
                    (paddr == REG_STAT) | (paddr == REG_PAR);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;

  logic        hold_ff, skip_ff, active_ff, pulse_ff, sck_ff;
  logic [31:0] tx_ff, instr_ff, rx_ff, sent_ff;
  logic [12:0] par_ff;
  logic [5:0]  bits_ff;
  logic [DW-1:0] div_ff;
  logic [WW-1:0] wait_ff;
  logic        go, go_ok, skip_hit, tick, is_erase, is_write;
  assign go       = wr_en & (paddr == REG_CTRL) & pwdata[CTRL_GO];
  assign go_ok    = go & ~active_ff & (wait_ff == '0) & hold_ff;
  assign skip_hit = skip_ff & (tx_ff[7:0] == ERASED_BYTE) &
                    (((tx_ff[31:24] & ~OP_HI_MASK) == OP_WR_FLASH) ||
                     (tx_ff[31:24] == OP_WR_EE));
  assign tick     = active_ff & (div_ff == '0);
  // The shifter is still one rotation short when done fires, so decode the stored copy.
  assign is_erase = (sent_ff[31:24] == OP_PREFIX) && (sent_ff[23:16] == SUB_ERASE);
  assign is_write = ((sent_ff[31:24] & ~OP_HI_MASK) == OP_WR_FLASH) ||
                    (sent_ff[31:24] == OP_WR_EE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= 1'b1;
      skip_ff <= 1'b0;
      par_ff  <= 13'h0800;
      tx_ff   <= 32'h00000000;
    end else if (wr_en) begin
      if (paddr == REG_CTRL) hold_ff <= pwdata[CTRL_HOLD];
      if (paddr == REG_CTRL) skip_ff <= pwdata[CTRL_SKIP];
      if (paddr == REG_TX && !active_ff) tx_ff <= pwdata;
      if (paddr == REG_PAR) par_ff <= pwdata[12:0];
    end
  end

  // Shift engine: mosi changes on the falling edge, miso is taken on the rising one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_ff <= 1'b0;
      pulse_ff  <= 1'b0;
      sck_ff    <= 1'b0;
      bits_ff   <= 6'd0;
      div_ff    <= '0;
      instr_ff  <= 32'h00000000;
      rx_ff     <= 32'h00000000;
    end else if (!active_ff) begin
      if (go_ok && !skip_hit) begin
        active_ff <= 1'b1;
        pulse_ff  <= 1'b0;
        bits_ff   <= 6'd32;
        instr_ff  <= tx_ff;
        div_ff    <= DW'(SCK_HALF_CYC - 1);
      end else if (wr_en && paddr == REG_CTRL && pwdata[CTRL_PULSE] && hold_ff) begin
        active_ff <= 1'b1;
        pulse_ff  <= 1'b1;
        bits_ff   <= 6'd0;
        div_ff    <= DW'(SCK_HALF_CYC - 1);
      end
    end else if (tick) begin
      div_ff <= DW'(SCK_HALF_CYC - 1);
      sck_ff <= ~sck_ff;
      if (!sck_ff) begin
        if (!pulse_ff) begin
          rx_ff   <= {rx_ff[30:0], miso_s};
          bits_ff <= bits_ff - 6'd1;
        end
      end else begin
        instr_ff <= pulse_ff ? instr_ff : {instr_ff[30:0], instr_ff[31]};
        if (bits_ff == 6'd0) active_ff <= 1'b0;
      end
    end else begin
      div_ff <= div_ff - DW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sent_ff <= 32'h00000000;
    else if (go_ok && !skip_hit) sent_ff <= tx_ff;
  end

  logic done;
  assign done = tick & sck_ff & (bits_ff == 6'd0) & ~pulse_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wait_ff <= WW'(PWRUP_WAIT_CYC);
    else if (done && is_erase) wait_ff <= WW'(ERASE_WAIT_CYC);
    else if (done && is_write) wait_ff <= WW'(WRITE_WAIT_CYC);
    else if (wait_ff != '0) wait_ff <= wait_ff - WW'(1);
  end

  logic echo_ok;
  assign echo_ok = (rx_ff[15:8] == sent_ff[23:16]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (rd_setup) begin
      unique case (paddr)
        REG_CTRL: prdata <= {28'h0000000, skip_ff, 2'b00, hold_ff};
        REG_TX:   prdata <= tx_ff;
        REG_RX:   prdata <= rx_ff;
        REG_STAT: prdata <= {28'h0000000, rb_s, echo_ok, wait_ff != '0, active_ff};
        REG_PAR:  prdata <= {19'h00000, par_ff[12:8], prd_s};
        default:  prdata <= 32'h00000000;
      endcase
    end
  end

  assign link.prog_reset_n      = ~hold_ff;
  assign link.sck               = sck_ff;
  assign link.mosi              = instr_ff[31];
  assign link.par_wdata         = par_ff[7:0];
  assign link.clock_action_bit0 = par_ff[PAR_CA_LO];
  assign link.clock_action_bit1 = par_ff[PAR_CA_LO+1];
  assign link.byte_select       = par_ff[PAR_BSEL];
  assign link.oe_n              = par_ff[PAR_OE_N];
  assign link.par_load          = par_ff[PAR_LOAD];
endmodule

// ===== test/mpi_monitor.sv
`timescale 1ns/10ps
module mpi_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic prog_reset_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic oe_n,
  input wire logic par_rdata_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Three samples is the shortest phase that still exceeds two oscillator cycles.
  sequence s_high3;
    sck [*3];
  endsequence
  sequence s_low3;
    !sck [*3];
  endsequence
  a_sck_high_min: assert property (
    $rose(sck) |-> s_high3) else $error("sck high too short");
  a_sck_low_min: assert property (
    $fell(sck) |-> s_low3) else $error("sck low too short");
  a_mosi_hold: assert property (
    $rose(sck) |-> $stable(mosi) [*3]) else $error("mosi moved at sck rise");
  a_mosi_shift: assert property (
    $changed(mosi) |-> !sck) else $error("mosi moved while sck high");
  a_miso_shift: assert property (
    $changed(miso) |-> !sck) else $error("miso moved while sck high");
  a_sck_idle_out: assert property (
    prog_reset_n |-> !sck) else $error("sck active outside session");
  a_read_start: assert property (
    $rose(par_rdata_oe) |-> !oe_n && !prog_reset_n) else $error("bus driven unasked");
  a_read_end: assert property (
    $rose(oe_n) |-> ##[1:5] !par_rdata_oe) else $error("bus not released");
  a_exit_release: assert property (
    prog_reset_n [*8] |-> !par_rdata_oe) else $error("bus driven after session");
endmodule

// ===== test/mpi_bench.sv
`timescale 1ns/10ps
module mpi_bench;
  import mpi_pkg::*;
  localparam logic [7:0] S0   = 8'h5a; // Arbitrary value.
  localparam logic [7:0] S1   = 8'h6b; // Arbitrary value.
  localparam logic [7:0] S2   = 8'h7c; // Arbitrary value.
  localparam logic [5:0] FUSE = 6'h25;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        prog_mode;
  logic        busy;
  logic        err;
  logic [31:0] rx;
  int          mismatches;
  int          checked;
  mpi_if link ();
  mpi_prog #(.PWRUP_WAIT_CYC(100), .ERASE_WAIT_CYC(3000),
    .WRITE_WAIT_CYC(200)) i_mpi_prog (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  mpi_dev #(.ERASE_SELF_CYC(2500), .WRITE_SELF_CYC(100), .FUSE_INIT(FUSE), .SIG0(S0),
    .SIG1(S1), .SIG2(S2)) i_mpi_dev (.pclk(pclk), .presetn(presetn), .link(link),
    .prog_mode(prog_mode), .busy(busy));
  mpi_monitor i_mpi_monitor (.pclk(pclk), .presetn(presetn),
    .prog_reset_n(link.prog_reset_n), .sck(link.sck), .mosi(link.mosi),
    .miso(link.miso), .oe_n(link.oe_n), .par_rdata_oe(link.par_rdata_oe));
  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    psel    <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rx      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Polling covers every programmer wait, so no count is assumed here.
  task automatic wait_idle();
    rx = 32'h3;
    for (int i = 0; i < 2000 && rx[1:0] != 2'b00; i++) begin
      apb(REG_STAT, 1'b0, 32'h0);
    end
    chk(rx[1:0], 2'b00);
  endtask
  task automatic xfer(input logic [31:0] ins);
    wait_idle();
    apb(REG_TX, 1'b1, ins);
    apb(REG_CTRL, 1'b1, 32'h3);
    wait_idle();
    apb(REG_RX, 1'b0, 32'h0);
  endtask
  task automatic rd(input logic [31:0] ins, input logic [7:0] e);
    xfer(ins);
    chk(rx[7:0], e);
  endtask
  task automatic par(input logic [7:0] d, input logic [1:0] ca, input logic bs,
                     input logic oe, input logic ld);
    apb(REG_PAR, 1'b1, {19'h0, ld, oe, bs, ca, d});
  endtask
  task automatic pload(input logic [7:0] d, input logic [1:0] ca);
    par(d, ca, 1'b0, 1'b1, 1'b1);
    par(d, ca, 1'b0, 1'b1, 1'b0);
  endtask
  task automatic pread(input logic bs, input logic [7:0] e);
    par(8'h00, CA_LOAD_ADDR, bs, 1'b0, 1'b0);
    repeat (8) @(posedge pclk);
    chk(link.par_rdata, e);
    chk(link.par_rdata_oe, 1'b1);
    par(8'h00, CA_LOAD_ADDR, bs, 1'b1, 1'b0);
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge pclk);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end
  initial begin
    presetn = 1'b0;
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    mismatches = 0;
    checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(REG_CTRL, 1'b1, 32'h1);
    apb(REG_STAT, 1'b0, 32'h0);
    chk(rx[1], 1'b1);
    xfer(32'hac530000);
    chk(rx[15:8], SUB_PROG_EN);
    chk(prog_mode, 1'b1);
    xfer(32'hac800000);
    apb(REG_CTRL, 1'b1, 32'h0);
    repeat (8) @(posedge pclk);
    apb(REG_CTRL, 1'b1, 32'h1);
    xfer(32'hac530000);
    rd(32'h20000500, ERASED_BYTE);
    rd(32'ha0007f00, ERASED_BYTE);
    rd(32'h58000000, 8'h06);
    rd(32'h50000000, {2'b00, FUSE});
    $display("test serial erase done");
    xfer(32'hc0007f5a);
    rd(32'ha0007f00, 8'h5a);
    xfer(32'hc0007fa5);
    rd(32'ha0007f00, 8'ha5);
    xfer(32'h4000053c);
    rd(32'h20000500, 8'h3c);
    xfer(32'h400005c3);
    rd(32'h20000500, 8'h00);
    rd(32'h28000500, ERASED_BYTE);
    rd(32'ha0000500, ERASED_BYTE);
    xfer(32'hace000f9);
    rd(32'h58000000, 8'h00);
    wait_idle();
    apb(REG_TX, 1'b1, 32'h400005ff);
    apb(REG_CTRL, 1'b1, 32'h9);
    apb(REG_CTRL, 1'b1, 32'hb);
    apb(REG_STAT, 1'b0, 32'h0);
    chk(rx[1:0], 2'b00);
    $display("test serial write done");
    pload(PCMD_RD_FL, CA_LOAD_CMD);
    pread(1'b1, 8'h00);
    pread(1'b0, {2'b00, FUSE});
    pload(PCMD_RD_SIG, CA_LOAD_CMD);
    for (int k = 0; k < 3; k++) begin
      pload(8'(k), CA_LOAD_ADDR);
      pread(1'b0, (k == 0) ? S0 : (k == 1) ? S1 : S2);
    end
    $display("test parallel read done");
    pload(PCMD_ERASE, CA_LOAD_CMD);
    for (int i = 0; i < 50 && link.ready_busy_out !== 1'b0; i++)
      @(posedge pclk);
    chk(link.ready_busy_out, 1'b0);
    chk(busy, 1'b1);
    pload(PCMD_RD_FL, CA_LOAD_CMD);
    pread(1'b1, 8'h00);
    for (int i = 0; i < 3000 && link.ready_busy_out !== 1'b1; i++)
      @(posedge pclk);
    chk(link.ready_busy_out, 1'b1);
    rd(32'h58000000, 8'h06);
    rd(32'h20000500, ERASED_BYTE);
    $display("test parallel erase done");
    apb(12'h0f0, 1'b0, 32'h0);
    chk(err, 1'b1);
    apb(REG_CTRL, 1'b1, 32'h5);
    apb(REG_STAT, 1'b0, 32'h0);
    chk(rx[0], 1'b1);
    wait_idle();
    apb(REG_CTRL, 1'b1, 32'h0);
    repeat (8) @(posedge pclk);
    chk(prog_mode, 1'b0);
    $display("test session end done");
    end_of_test();
  end
endmodule
